/* File: hw/watchdog_pkg.sv */
// shared constants, types and decoders for the watchdog register block
package watchdog_pkg;

    // ----------------------------------------------------------------
    // register map (avalon word address, one register per word)
    // ----------------------------------------------------------------
    localparam logic [1:0] IDX_CONTROL = 2'h0; // period and window fields
    localparam logic [1:0] IDX_STATUS = 2'h1;  // lock and sync busy
    localparam logic [1:0] IDX_KEY = 2'h2;     // protected change key
    localparam logic [1:0] BYTE_LANE_ZERO = 2'h0; // upper address bits of a mapped word

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int PERIOD_LSB = 0;
    localparam int WINDOW_LSB = 4;
    localparam int FIELD_W = 4;
    localparam int LOCK_BIT = 7;
    localparam int BUSY_BIT = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [31:0] READ_ZERO = 32'h00000000;
    localparam logic [3:0] CODE_OFF = 4'h0;
    localparam logic [3:0] CODE_MAX = 4'hb;

    // ----------------------------------------------------------------
    // timing in slow watchdog ticks; key window in bus accesses
    // ----------------------------------------------------------------
    localparam int COUNT_W = 14;
    localparam logic [3:0] TICK_SHIFT = 4'h2;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 14'h0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 14'h0001;
    localparam logic [2:0] KEY_WINDOW = 3'h4; // accesses the key stays open
    localparam logic [2:0] KEY_CLOSED = 3'h0;

    // ----------------------------------------------------------------
    // state enumerations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SYNC_IDLE, SYNC_FIRST, SYNC_SECOND} sync_state_type;
    typedef enum logic [1:0] {PHASE_OFF, PHASE_OPEN, PHASE_CLOSED} phase_type;

    // last tick index of a period code, reserved codes clamp to the longest
    function automatic logic [COUNT_W-1:0] tick_limit(input logic [3:0] code);
        logic [3:0] c;
        c = (code > CODE_MAX) ? CODE_MAX : code;
        return (COUNT_ONE << (c + TICK_SHIFT)) - COUNT_ONE;
    endfunction : tick_limit

    // period field of a control byte
    function automatic logic [3:0] period_of(input logic [7:0] ctrl);
        return ctrl[PERIOD_LSB +: FIELD_W];
    endfunction : period_of

    // window field of a control byte
    function automatic logic [3:0] window_of(input logic [7:0] ctrl);
        return ctrl[WINDOW_LSB +: FIELD_W];
    endfunction : window_of

endpackage : watchdog_pkg

/* File: hw/watchdog_counter.sv */
// time-out and window counter running on synchronised watchdog ticks
`timescale 1ns/1ps
module watchdog_counter import watchdog_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // tick and control
    input wire logic tick,
    input wire logic clearReq,
    input wire logic halt,
    input wire logic [3:0] periodCode,
    input wire logic [3:0] windowCode,
    // result
    output logic expired
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        phase_type phase;           // off, open or closed window
        logic [COUNT_W-1:0] count;  // ticks spent in current phase
        logic expired;              // sticky until system reset
    } cnt_type;

    cnt_type s;
    cnt_type next_s;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        if (s.expired) begin
            // held until the system reset pulls reset_n
            next_s.expired = 1'b1;
        end else if (periodCode == CODE_OFF || halt) begin
            next_s.phase = PHASE_OFF;
            next_s.count = COUNT_ZERO;
        end else if (clearReq) begin
            if (s.phase == PHASE_CLOSED) begin
                next_s.expired = 1'b1;
            end else begin
                next_s.count = COUNT_ZERO;
                next_s.phase = (windowCode != CODE_OFF) ? PHASE_CLOSED : PHASE_OPEN;
            end
        end else if (s.phase == PHASE_OFF) begin
            // first period after enable is a plain time-out
            next_s.phase = PHASE_OPEN;
            next_s.count = COUNT_ZERO;
        end else if (s.phase == PHASE_CLOSED && windowCode == CODE_OFF) begin
            // window mode switched off mid closed period
            next_s.phase = PHASE_OPEN;
            next_s.count = COUNT_ZERO;
        end else if (tick) begin
            if (s.phase == PHASE_CLOSED) begin
                if (s.count == tick_limit(windowCode)) begin
                    next_s.phase = PHASE_OPEN;
                    next_s.count = COUNT_ZERO;
                end else begin
                    next_s.count = s.count + COUNT_ONE;
                end
            end else if (s.count == tick_limit(periodCode)) begin
                next_s.expired = 1'b1;
            end else begin
                next_s.count = s.count + COUNT_ONE;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '{phase: PHASE_OFF, count: COUNT_ZERO, expired: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign expired = s.expired;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_EXPIRE_HOLDS: assert property (s.expired |=> s.expired)
        else $error("reset request dropped");
    AST_CLOSED_CLEAR: assert property (
        s.phase == PHASE_CLOSED && clearReq && !halt && periodCode != CODE_OFF
        |=> s.expired) else $error("clear in closed window not punished");
    AST_DISABLED_OFF: assert property (
        periodCode == CODE_OFF && !s.expired |=> s.phase == PHASE_OFF && !s.expired)
        else $error("counter runs while disabled");
    AST_TIMEOUT: assert property (
        s.phase == PHASE_OPEN && tick && !clearReq && !halt && !s.expired
        && periodCode != CODE_OFF && s.count == tick_limit(periodCode)
        |=> s.expired) else $error("time-out missed");
    AST_CLEAR_RESTART: assert property (
        s.phase == PHASE_OPEN && clearReq && !halt && !s.expired
        && periodCode != CODE_OFF |=> s.count == COUNT_ZERO && !s.expired)
        else $error("clear did not restart count");

endmodule : watchdog_counter

/* File: hw/watchdog_control_status_regs.sv */
// watchdog control and status registers with avalon-mm slave and sync
//
// Functional notes
// - nonzero window field selects window mode
// - window codes 1..11 give 8..8K ticks
// - nonzero period field enables the watchdog
// - period codes 1..11 give 8..8K ticks
// - in window mode period is open window
// - lock set makes control register read-only
// - lock only set; cleared in debug only
// - boot period nonzero sets lock automatically
// - busy flag covers control crossing to watchdog
// - control and lock need the unlock key
// - control reset value comes from boot fuse
// - missed clear issues system reset; clear restarts
// - clear in closed window resets; open follows
`timescale 1ns/1ps
module watchdog_control_status_regs import watchdog_pkg::*; #(
    // unlock key value, arbitrary
    parameter logic [7:0] UNLOCK_KEY = 8'h5a
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // slow watchdog clock pin
    input wire logic wdtClkPin,
    // cpu side
    input wire logic wdClear,
    input wire logic debugMode,
    input wire logic debugHalt,
    input wire logic [7:0] bootConfigFuse,
    // reset request
    output logic systemReset
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic sync1;                 // first pin synchroniser stage
        logic sync2;                 // second pin synchroniser stage
        logic prev;                  // previous synchronised level
        logic bootDone;              // fuse already applied
        logic [7:0] control;         // software visible control byte
        logic [7:0] applied;         // control seen by the counter
        logic lock;                  // control write protect
        sync_state_type sync;        // crossing progress
        logic [2:0] keyCount;        // accesses left with key open
        logic ack;                   // second cycle of a transfer
        logic [31:0] rdata;          // registered read data
        logic clearPending;          // clear waiting for a tick
    } regs_type;

    regs_type s;
    regs_type next_s;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    logic request;        // read or write held by the master
    logic accept;         // transfer completes this edge
    logic lane0;          // low byte enabled on write
    logic wordOk;         // aligned, mapped address
    logic [1:0] index;    // register index
    logic tick;           // one cycle per rising watchdog edge
    logic keyOpen;        // protected write allowed now
    logic ctrlWrite;      // protected control write taken
    logic statWrite;      // protected status write taken
    logic busy;           // crossing in progress
    logic counterExpired; // counter wants a system reset

    // register index of a word address, used by read and write paths
    function automatic logic [1:0] word_index(input logic [3:0] addr);
        return addr[1:0];
    endfunction : word_index

    assign request = read || write;
    assign accept = request && s.ack;
    assign index = word_index(address);
    assign wordOk = (address[3:2] == BYTE_LANE_ZERO) && (index <= IDX_KEY);
    assign lane0 = byteenable[0];
    assign keyOpen = s.keyCount != KEY_CLOSED;
    assign busy = s.sync != SYNC_IDLE;
    assign tick = s.sync2 && !s.prev;
    assign ctrlWrite = accept && write && wordOk && lane0 && keyOpen
                       && index == IDX_CONTROL;
    assign statWrite = accept && write && wordOk && lane0 && keyOpen
                       && index == IDX_STATUS;

    // one wait cycle on every transfer, so read data can come from a flop
    assign waitrequest = request && !s.ack;
    assign readdata = s.rdata;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;

        // pin synchroniser; only the second stage feeds logic
        next_s.sync1 = wdtClkPin;
        next_s.sync2 = s.sync1;
        next_s.prev = s.sync2;

        // bus handshake: ack toggles in for exactly one cycle
        next_s.ack = request && !s.ack;

        // read data latched in the wait cycle
        if (read && !s.ack) begin
            next_s.rdata = READ_ZERO;
            if (wordOk && index == IDX_CONTROL) begin
                next_s.rdata[7:0] = s.control;
            end else if (wordOk && index == IDX_STATUS) begin
                next_s.rdata[7:0] = STATUS_RESET;
                next_s.rdata[LOCK_BIT] = s.lock;
                next_s.rdata[BUSY_BIT] = busy;
            end
        end

        // key window: opened by the key, spent by accesses
        if (accept && write && wordOk && lane0 && index == IDX_KEY) begin
            next_s.keyCount = (writedata[7:0] == UNLOCK_KEY) ? KEY_WINDOW : KEY_CLOSED;
        end else if (ctrlWrite || statWrite) begin
            next_s.keyCount = KEY_CLOSED;
        end else if (accept && keyOpen) begin
            next_s.keyCount = s.keyCount - 3'h1;
        end

        // crossing: hold the new value for two watchdog ticks
        case (s.sync)
            SYNC_IDLE: begin
                next_s.sync = SYNC_IDLE;
            end
            SYNC_FIRST: begin
                if (tick) begin
                    next_s.sync = SYNC_SECOND;
                end
            end
            SYNC_SECOND: begin
                if (tick) begin
                    next_s.applied = s.control;
                    next_s.sync = SYNC_IDLE;
                end
            end
            default: begin
                next_s.sync = SYNC_IDLE;
            end
        endcase

        if (ctrlWrite && !s.lock) begin
            next_s.control = writedata[7:0];
            next_s.sync = SYNC_FIRST;
        end

        if (statWrite) begin
            if (writedata[LOCK_BIT]) begin
                next_s.lock = 1'b1;
            end else if (debugMode) begin
                next_s.lock = 1'b0;
            end
        end

        // clear request waits for a tick; a second one meanwhile is dropped
        if (s.clearPending && tick) begin
            next_s.clearPending = 1'b0;
        end else if (wdClear) begin
            next_s.clearPending = 1'b1;
        end

        if (!s.bootDone) begin
            next_s.bootDone = 1'b1;
            next_s.control = bootConfigFuse;
            next_s.applied = bootConfigFuse;
            next_s.sync = SYNC_IDLE;
            next_s.lock = period_of(bootConfigFuse) != CODE_OFF;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '{sync1: 1'b0, sync2: 1'b0, prev: 1'b0, bootDone: 1'b0,
                   control: CONTROL_RESET, applied: CONTROL_RESET,
                   lock: STATUS_RESET[LOCK_BIT], sync: SYNC_IDLE,
                   keyCount: KEY_CLOSED, ack: 1'b0, rdata: READ_ZERO,
                   clearPending: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // counter in the tick domain
    // ----------------------------------------------------------------
    // counter steps on ticks
    watchdog_counter counter (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .tick(tick),
        .clearReq(s.clearPending && tick),
        .halt(debugHalt || !s.bootDone),
        .periodCode(period_of(s.applied)),
        .windowCode(window_of(s.applied)),
        .expired(counterExpired)
    );

    assign systemReset = counterExpired;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence fresh_request;
        request && !s.ack;
    endsequence

    sequence one_wait_then_done;
        waitrequest ##1 !waitrequest;
    endsequence

    sequence crossing_done;
        s.sync == SYNC_SECOND && tick && !ctrlWrite;
    endsequence

    AST_ONE_WAIT: assert property (fresh_request |-> one_wait_then_done)
        else $error("transfer not answered after one wait cycle");
    AST_BUSY_ON_WRITE: assert property (ctrlWrite && !s.lock |=> busy)
        else $error("busy not raised by control write");
    AST_BUSY_CLEARS: assert property (
        crossing_done |=> !busy && s.applied == $past(s.control))
        else $error("crossing did not finish");
    AST_LOCK_FREEZES: assert property (
        s.bootDone && s.lock |=> $stable(s.control))
        else $error("locked control changed");
    AST_LOCK_STICKY: assert property (
        s.bootDone && s.lock && !debugMode |=> s.lock)
        else $error("lock cleared outside debug");
    AST_KEY_NEEDED: assert property (
        s.bootDone && !keyOpen |=> $stable(s.control) && $stable(s.lock))
        else $error("protected write without key");
    AST_BOOT_LOCK: assert property (
        !s.bootDone && period_of(bootConfigFuse) != CODE_OFF
        |=> s.lock && s.control == $past(bootConfigFuse))
        else $error("boot enable did not lock");
    AST_UNMAPPED_ZERO: assert property (
        read && !s.ack && !wordOk |=> readdata == READ_ZERO)
        else $error("unmapped read not zero");

    // register reads seen in their wait cycle
    sequence control_read;
        read && !s.ack && wordOk && index == IDX_CONTROL;
    endsequence

    sequence status_read;
        read && !s.ack && wordOk && index == IDX_STATUS;
    endsequence

    AST_STATUS_READ: assert property (
        status_read |=> readdata[BUSY_BIT] == $past(busy)
        && readdata[LOCK_BIT] == $past(s.lock))
        else $error("status read hides busy or lock");

    AST_CONTROL_READ: assert property (
        control_read |=> readdata[7:0] == $past(s.control))
        else $error("control read mismatch");

    AST_KEY_OPENS: assert property (
        accept && write && wordOk && lane0 && index == IDX_KEY
        && writedata[7:0] == UNLOCK_KEY |=> keyOpen)
        else $error("unlock key did not open the window");

    AST_LOCK_SETS: assert property (
        s.bootDone && statWrite && writedata[LOCK_BIT] |=> s.lock)
        else $error("lock write did not set lock");

    AST_LOCK_REFUSES: assert property (
        s.bootDone && ctrlWrite && s.lock && !busy |=> !busy)
        else $error("locked control write started a crossing");

endmodule : watchdog_control_status_regs

/* File: sim/test_watchdog_control_status_regs.sv */
// self-checking bench for the watchdog control and status registers
`timescale 1ns/1ps
module test_watchdog_control_status_regs import watchdog_pkg::*;;
    // ------------------------------------------------------------
    // signals and bench state
    // ------------------------------------------------------------
    localparam logic [7:0] TEST_KEY = 8'h3c; // unlock key, arbitrary
    localparam logic [3:0] A_CTRL = 4'h0;    // control byte address
    localparam logic [3:0] A_STAT = 4'h1;    // status word address
    localparam logic [3:0] A_KEY = 4'h2;     // key word address
    localparam logic [31:0] LOCKED = 32'h00000080; // lock bit alone
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [3:0] byteenable = 4'h1;
    logic [31:0] readdata;
    logic waitrequest;
    logic wdtClkPin = 1'b0;
    logic wdClear = 1'b0;
    logic debugMode = 1'b0;
    logic debugHalt = 1'b0;
    logic [7:0] bootConfigFuse = 8'h00;
    logic systemReset;
    logic [2:0] tickDiv = 3'h0;          // divides core clock for ticks
    logic [31:0] seed = 32'h966fb270;    // xorshift state
    logic [32:0] expq[$];                // {compare, value} per read
    int fail_count = 0;
    int checked = 0;

    watchdog_control_status_regs #(.UNLOCK_KEY(TEST_KEY)) dut_u (
        .core_clk(core_clk), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .wdtClkPin(wdtClkPin),
        .wdClear(wdClear), .debugMode(debugMode), .debugHalt(debugHalt),
        .bootConfigFuse(bootConfigFuse), .systemReset(systemReset)
    );

    // ------------------------------------------------------------
    // clocks
    // ------------------------------------------------------------
    // core clock, 25 ns period
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    // fast watchdog tick: one rising edge every 8 core cycles
    always @(posedge core_clk) begin
        tickDiv <= tickDiv + 3'h1;
        wdtClkPin <= tickDiv[2];
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // xorshift source, fixed start
    function automatic logic [31:0] randWord();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : randWord

    // single compare point
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one avalon transfer; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        logic w;
        @(posedge core_clk);
        read <= ~wr;
        write <= wr;
        address <= a;
        writedata <= d;
        // waitrequest is combinational, so look at it mid-cycle; the value
        // seen there is the one the next rising edge samples
        do begin
            @(negedge core_clk);
            w = waitrequest;
            q = readdata;
            @(posedge core_clk);
        end while (w !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    // write, with random upper bits that the block must ignore
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {randWord() & 32'hffffff00} | {24'h0, d}, q);
    endtask : wr

    // read whose result the monitor compares
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        expq.push_back({1'b1, exp});
        bus(1'b0, a, 32'h0, q);
    endtask : rd

    // protected write: key first, then the target
    task automatic pwr(input logic [3:0] a, input logic [7:0] d);
        wr(A_KEY, TEST_KEY);
        wr(a, d);
    endtask : pwr

    // poll status until the crossing has finished
    task automatic waitBusy();
        logic [31:0] q;
        // no poll limit: a stuck crossing is caught by the watchdog
        do begin
            expq.push_back({1'b0, 32'h0});
            bus(1'b0, A_STAT, 32'h0, q);
        end while (q[BUSY_BIT] !== 1'b0);
    endtask : waitBusy

    // reset with a given boot fuse, held three cycles
    task automatic doReset(input logic [7:0] fuse);
        reset_n <= 1'b0;
        bootConfigFuse <= fuse;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask : doReset

    // one-cycle clear pulse
    task automatic pulseClear();
        wdClear <= 1'b1;
        @(posedge core_clk);
        wdClear <= 1'b0;
    endtask : pulseClear

    // verdict, the only exit
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // monitor: read data is settled in the cycle waitrequest is low
    // ------------------------------------------------------------
    always @(negedge core_clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            if (expq.size() == 0) begin
                check(readdata, 32'hdeadbeef); // read nobody asked for
            end else if (expq[0][32]) begin
                check(readdata, 32'(expq.pop_front())); // value noted by the driver
            end else begin
                void'(expq.pop_front());
            end
        end
    end

    // watchdog against hangs, well past the expected run
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        test_done();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        doReset(8'h00);
        rd(A_CTRL, {24'h0, CONTROL_RESET});
        rd(A_STAT, {24'h0, STATUS_RESET});
        rd(4'hc, READ_ZERO);                // unmapped place reads zero
        rd(A_KEY, READ_ZERO);               // key is write-only
        wr(A_CTRL, 8'(randWord()) | 8'h11); // no key, must be dropped
        rd(A_CTRL, READ_ZERO);
        // window set but period off: watchdog stays idle
        pwr(A_CTRL, 8'h30);
        rd(A_STAT, 32'h1);
        waitBusy();
        rd(A_STAT, READ_ZERO);
        rd(A_CTRL, 32'h30);
        pwr(A_STAT, 8'h80);
        rd(A_STAT, LOCKED);
        pwr(A_CTRL, 8'h05);
        rd(A_CTRL, 32'h30);
        pwr(A_STAT, 8'h00);
        rd(A_STAT, LOCKED);
        debugMode <= 1'b1;
        pwr(A_STAT, 8'h00);
        debugMode <= 1'b0;
        rd(A_STAT, READ_ZERO);
        check({31'h0, systemReset}, 32'h0);
        // shortest period, no clear: 8 ticks then reset
        pwr(A_CTRL, 8'h01);
        waitBusy();
        repeat (48) @(posedge core_clk);
        check({31'h0, systemReset}, 32'h0);
        repeat (40) @(posedge core_clk);
        check({31'h0, systemReset}, 32'h1);
        // 16-tick period kept alive by clears at random gaps
        doReset(8'h00);
        pwr(A_CTRL, 8'h02);
        waitBusy();
        for (int i = 0; i < 6; i++) begin
            repeat (40 + (randWord() % 40)) @(posedge core_clk);
            pulseClear();
            check({31'h0, systemReset}, 32'h0);
        end
        repeat (200) @(posedge core_clk);
        check({31'h0, systemReset}, 32'h1);
        // window mode: a second clear inside the closed part resets
        doReset(8'h00);
        pwr(A_CTRL, 8'h11);
        waitBusy();
        pulseClear();
        repeat (24) @(posedge core_clk);
        check({31'h0, systemReset}, 32'h0);
        pulseClear();
        repeat (24) @(posedge core_clk);
        check({31'h0, systemReset}, 32'h1);
        // fuse with a running period locks at boot
        doReset(8'h03);
        rd(A_CTRL, 32'h03);
        rd(A_STAT, LOCKED);
        // debug halt keeps the 32-tick period from running out
        debugHalt <= 1'b1;
        repeat (300) @(posedge core_clk);
        check({31'h0, systemReset}, 32'h0);
        // released: a full plain period, then the reset request
        debugHalt <= 1'b0;
        repeat (300) @(posedge core_clk);
        check({31'h0, systemReset}, 32'h1);
        test_done();
    end
endmodule : test_watchdog_control_status_regs
